// ---- inc/adc_i2c_pkg.sv ----
// Shared constants for the converter sequencer and its bus master.
// Assumes a single 40 MHz system clock on both ends of the two-wire link.
package adc_i2c_pkg;
	localparam int CLOCK_MHZ = 40;
	// Arbitrary value
	localparam logic [4:0] DEVICE_TYPE_PREFIX = 5'h0d;
	localparam int RESULT_WIDTH = 10;
	// Command byte field positions
	localparam int CMD_SINGLE_ENDED = 7;
	localparam int CMD_CHANNEL_BIT0 = 4;
	localparam int CMD_REFERENCE_POWER = 3;
	localparam int CMD_CONVERTER_POWER = 2;
	// Bits received when a field has fully arrived (MSB first)
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CHANNEL_BIT0_ARRIVAL = 4'(8 - CMD_CHANNEL_BIT0);
	// Byte 0 carries result[9:2], byte 1 carries result[1:0] left aligned
	localparam int RESULT_BYTE0_SHIFT = 2;
	localparam int RESULT_BYTE1_SHIFT = 8 - RESULT_BYTE0_SHIFT;
	// Converter power-up, least time rounded up
	localparam int POWER_UP_NS = 1400;
	localparam logic [5:0] POWER_UP_CYCLES = 6'((POWER_UP_NS * CLOCK_MHZ + 999) / 1000);
	// Quiet time after a repeated start, least time rounded up
	localparam int QUIET_NS = 3700;
	localparam logic [7:0] QUIET_CYCLES = 8'((QUIET_NS * CLOCK_MHZ + 999) / 1000);
	// Reference settling for a typical reference capacitor
	localparam int REF_SETTLE_US = 1400;
	localparam int REF_SETTLE_CYCLES = REF_SETTLE_US * CLOCK_MHZ;
	// Master clock divider: one quarter of an SCL period
	localparam logic [1:0] SCL_QUARTER_CYCLES = 2'h3;
	// Cycles the strap pins settle after reset before they are taken
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
endpackage

// ---- inc/adc_i2c_link.sv ----
// Two-wire link joining the converter device and its bus master.
// Both lines are open drain; a line nobody pulls low reads high.
`timescale 1ns/1ps
interface adc_i2c_link;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);
endinterface

// ---- src/adc_sequencer_device.sv ----
// Slave end: address match, command byte decode, conversion start,
// reference and converter power sequencing, two-byte result readout.
// Assumes the converter core answers on the same clock with i_result_valid.
`timescale 1ns/1ps
module adc_sequencer_device (
	// Clock and reset
	input  wire logic                                 i_clock,
	input  wire logic                                 i_resetn,
	// Two-wire link
	adc_i2c_link.device                               bus,
	// Address straps
	input  wire logic                                 i_device_select_pin_hi,
	input  wire logic                                 i_device_select_pin_lo,
	// Converter core
	input  wire logic [adc_i2c_pkg::RESULT_WIDTH-1:0] i_result,
	input  wire logic                                 i_result_valid,
	output logic                                      o_convert_start,
	output logic                                      o_converter_on,
	output logic                                      o_converter_ready,
	output logic                                      o_reference_on,
	output logic [2:0]                                o_channel,
	output logic                                      o_single_ended
);
	import adc_i2c_pkg::*;

	typedef enum logic [2:0] {
		IDLE, ADDR, ADDR_ACK, CMD, CMD_ACK, TX, TX_ACK
	} state_type;

	typedef struct packed {
		logic                    scl_meta;
		logic                    scl_sync;
		logic                    scl_prev;
		logic                    sda_meta;
		logic                    sda_sync;
		logic                    sda_prev;
		logic [1:0]              pin_meta;
		logic [1:0]              pin_sync;
		logic [1:0]              select;
		logic [1:0]              strap_cnt;
		logic                    strap_done;
		state_type               state;
		logic [3:0]              cnt;
		logic [7:0]              shreg;
		logic                    rw;
		logic                    byte_sel;
		logic                    master_ack;
		logic                    sda_oe;
		logic [7:0]              command;
		logic                    cmd_valid;
		logic                    write_session;
		logic                    readable;
		logic                    converting;
		logic                    convert_start;
		logic                    converter_on;
		logic [5:0]              pwr_cnt;
		logic                    converter_ready;
		logic                    reference_on;
		logic                    ref_pending;
		logic [2:0]              channel;
		logic                    single_ended;
		logic [RESULT_WIDTH-1:0] result;
	} regs_type;

	regs_type r;
	regs_type next_r;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic       addr_match;
	logic [7:0] next_bits;
	logic [7:0] load_byte;

	assign scl_rise   = r.scl_sync && !r.scl_prev;
	assign scl_fall   = !r.scl_sync && r.scl_prev;
	assign start_seen = r.scl_sync && r.scl_prev && r.sda_prev && !r.sda_sync;
	assign stop_seen  = r.scl_sync && r.scl_prev && !r.sda_prev && r.sda_sync;
	assign next_bits  = {r.shreg[6:0], r.sda_sync};
	// Addresses decoded before the straps are taken are ignored
	assign addr_match = r.strap_done && r.shreg[7:3] == DEVICE_TYPE_PREFIX
		&& r.shreg[2:1] == r.select;
	// Byte 0 holds the result MSB, byte 1 starts with its two LSBs
	assign load_byte  = r.byte_sel ? 8'(r.result << RESULT_BYTE1_SHIFT)
		: 8'(r.result >> RESULT_BYTE0_SHIFT);

	always_comb begin
		next_r = r;
		next_r.scl_meta = bus.scl;
		next_r.scl_sync = r.scl_meta;
		next_r.scl_prev = r.scl_sync;
		next_r.sda_meta = bus.sda;
		next_r.sda_sync = r.sda_meta;
		next_r.sda_prev = r.sda_sync;
		next_r.pin_meta = {i_device_select_pin_hi, i_device_select_pin_lo};
		next_r.pin_sync = r.pin_meta;
		next_r.convert_start = 1'b0;

		// Straps are taken once, after the synchroniser has filled
		if (!r.strap_done) begin
			if (r.strap_cnt == STRAP_SETTLE_CYCLES) begin
				next_r.select     = r.pin_sync;
				next_r.strap_done = 1'b1;
			end else begin
				next_r.strap_cnt = r.strap_cnt + 2'h1;
			end
		end

		if (i_result_valid) begin
			next_r.result     = i_result;
			next_r.converting = 1'b0;
		end

		if (start_seen || stop_seen) begin
			// A pending reference enable takes effect at stop or repeated start
			if (r.ref_pending) begin
				next_r.reference_on = 1'b1;
				next_r.ref_pending  = 1'b0;
			end
			next_r.write_session = 1'b0;
			next_r.sda_oe        = 1'b0;
			next_r.cnt           = 4'h0;
			next_r.state         = start_seen ? ADDR : IDLE;
		end else if (scl_rise) begin
			unique case (r.state)
				ADDR, CMD: begin
					next_r.shreg = next_bits;
					next_r.cnt   = r.cnt + 4'h1;
					if (r.state == CMD && r.cnt + 4'h1 == CHANNEL_BIT0_ARRIVAL) begin
						next_r.convert_start = 1'b1;
						next_r.converting    = 1'b1;
						next_r.readable      = 1'b1;
						next_r.single_ended  = next_bits[3];
						next_r.channel       = next_bits[2:0];
					end
					if (r.state == CMD && r.cnt + 4'h1 == BYTE_BITS) begin
						next_r.command   = next_bits;
						next_r.cmd_valid = 1'b1;
						if (!next_bits[CMD_REFERENCE_POWER]) begin
							next_r.reference_on = 1'b0;
							next_r.ref_pending  = 1'b0;
						end else if (!r.reference_on) begin
							next_r.ref_pending = 1'b1;
						end
						// An enabled reference simply stays on
					end
				end
				TX_ACK: next_r.master_ack = !r.sda_sync;
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (r.state)
				ADDR: begin
					if (r.cnt == BYTE_BITS) begin
						// Reads before any conversion are not acknowledged
						if (addr_match && (!r.shreg[0] || r.readable)) begin
							next_r.sda_oe = 1'b1;
							next_r.rw     = r.shreg[0];
							next_r.state  = ADDR_ACK;
							if (!r.shreg[0]) begin
								next_r.write_session = 1'b1;
							end
						end else begin
							next_r.state = IDLE;
						end
					end
				end
				ADDR_ACK: begin
					if (r.rw) begin
						next_r.byte_sel = 1'b1;
						next_r.sda_oe   = !r.result[RESULT_WIDTH-1];
						next_r.shreg    = {r.result[RESULT_WIDTH-2:RESULT_BYTE0_SHIFT], 1'b0};
						next_r.cnt      = 4'h1;
						next_r.state    = TX;
					end else begin
						next_r.sda_oe = 1'b0;
						next_r.cnt    = 4'h0;
						next_r.state  = CMD;
					end
				end
				CMD: begin
					if (r.cnt == BYTE_BITS) begin
						next_r.sda_oe = 1'b1;
						next_r.state  = CMD_ACK;
					end
				end
				CMD_ACK: begin
					next_r.sda_oe = 1'b0;
					next_r.cnt    = 4'h0;
					next_r.state  = CMD;
				end
				TX: begin
					if (r.cnt == BYTE_BITS) begin
						next_r.sda_oe = 1'b0;
						next_r.state  = TX_ACK;
					end else begin
						next_r.sda_oe = !r.shreg[7];
						next_r.shreg  = {r.shreg[6:0], 1'b0};
						next_r.cnt    = r.cnt + 4'h1;
					end
				end
				TX_ACK: begin
					if (r.master_ack) begin
						next_r.byte_sel = !r.byte_sel;
						next_r.sda_oe   = !load_byte[7];
						next_r.shreg    = {load_byte[6:0], 1'b0};
						next_r.cnt      = 4'h1;
						next_r.state    = TX;
					end else begin
						next_r.sda_oe = 1'b0;
						next_r.state  = IDLE;
					end
				end
				default: begin
				end
			endcase
		end

		// Mode 00 keeps the converter up only for the addressed write and conversion
		next_r.converter_on = r.write_session || r.converting
			|| (r.cmd_valid && r.command[CMD_CONVERTER_POWER]);
		if (!r.converter_on) begin
			next_r.pwr_cnt         = 6'h00;
			next_r.converter_ready = 1'b0;
		end else if (r.pwr_cnt == POWER_UP_CYCLES) begin
			next_r.converter_ready = 1'b1;
		end else begin
			next_r.pwr_cnt = r.pwr_cnt + 6'h01;
		end
	end

	// Reset clears the reference, so it starts off
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign bus.dev_sda_o     = 1'b0;
	assign bus.dev_sda_oe    = r.sda_oe;
	assign o_convert_start   = r.convert_start;
	assign o_converter_on    = r.converter_on;
	assign o_converter_ready = r.converter_ready;
	assign o_reference_on    = r.reference_on;
	assign o_channel         = r.channel;
	assign o_single_ended    = r.single_ended;
endmodule

// ---- src/adc_sequencer_host.sv ----
// Master end: issues command writes and two-byte result reads, with
// repeated-start holding, post-restart quiet time and reference settling.
// Assumes the slave never stretches SCL.
`timescale 1ns/1ps
module adc_sequencer_host #(
	parameter int SETTLE_CYCLES = adc_i2c_pkg::REF_SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic                                 i_clock,
	input  wire logic                                 i_resetn,
	// Two-wire link
	adc_i2c_link.host                                 bus,
	// Requests
	input  wire logic                                 i_request,
	input  wire logic                                 i_request_read,
	input  wire logic                                 i_request_hold,
	input  wire logic [7:0]                           i_command,
	input  wire logic                                 i_use_internal_reference,
	input  wire logic [1:0]                           i_device_select,
	// Answers
	output logic                                      o_busy,
	output logic                                      o_done,
	output logic                                      o_refused,
	output logic [adc_i2c_pkg::RESULT_WIDTH-1:0]      o_result
);
	import adc_i2c_pkg::*;

	typedef enum logic [2:0] {IDLE, HELD, START, QUIET, BITS, STOP} state_type;

	typedef struct packed {
		state_type               state;
		logic                    sda_meta;
		logic                    sda_sync;
		logic [1:0]              div;
		logic [1:0]              phase;
		logic [3:0]              bitn;
		logic [1:0]              byte_idx;
		logic [7:0]              shreg;
		logic [7:0]              rx;
		logic [7:0]              byte0;
		logic                    read;
		logic                    hold;
		logic                    repeated;
		logic                    acked;
		logic [7:0]              command;
		logic                    conv_started;
		logic                    ref_seen;
		logic                    settle_due;
		logic [16:0]             settle_cnt;
		logic [7:0]              quiet_cnt;
		logic                    scl_oe;
		logic                    sda_oe;
		logic                    busy;
		logic                    done;
		logic                    refused;
		logic [RESULT_WIDTH-1:0] result;
	} regs_type;

	regs_type r;
	regs_type next_r;

	logic tick;
	logic sending;

	assign tick    = r.div == SCL_QUARTER_CYCLES - 2'h1;
	assign sending = !r.read || r.byte_idx == 2'h0;

	always_comb begin
		next_r = r;
		next_r.sda_meta = bus.sda;
		next_r.sda_sync = r.sda_meta;
		next_r.div      = tick ? 2'h0 : r.div + 2'h1;
		next_r.done     = 1'b0;
		next_r.refused  = 1'b0;
		if (r.settle_cnt != 17'h0) begin
			next_r.settle_cnt = r.settle_cnt - 17'h1;
		end
		next_r.busy = r.settle_cnt > 17'h1 || !(r.state == IDLE || r.state == HELD);

		unique case (r.state)
			IDLE, HELD: begin
				if (i_request && !r.busy) begin
					if (i_request_read && !r.conv_started) begin
						next_r.refused = 1'b1;
						next_r.done    = 1'b1;
					end else begin
						next_r.shreg    = {DEVICE_TYPE_PREFIX, i_device_select, i_request_read};
						next_r.command  = i_command;
						// Internal reference keeps the bit set, external keeps it clear
						next_r.command[CMD_REFERENCE_POWER] = i_use_internal_reference;
						next_r.read     = i_request_read;
						next_r.hold     = i_request_hold;
						next_r.repeated = r.state == HELD;
						next_r.phase    = 2'h0;
						next_r.busy     = 1'b1;
						next_r.state    = START;
					end
				end
			end
			START: begin
				if (tick) begin
					next_r.phase = r.phase + 2'h1;
					unique case (r.phase)
						2'h0: next_r.sda_oe = 1'b0;
						2'h1: next_r.scl_oe = 1'b0;
						2'h2: next_r.sda_oe = 1'b1;
						2'h3: begin
							next_r.scl_oe    = 1'b1;
							next_r.bitn      = 4'h0;
							next_r.byte_idx  = 2'h0;
							next_r.quiet_cnt = QUIET_CYCLES;
							next_r.state     = r.repeated ? QUIET : BITS;
						end
					endcase
				end
			end
			QUIET: begin
				// No clocking right after a restart keeps the conversion clean
				if (r.quiet_cnt == 8'h00) begin
					next_r.div   = 2'h0;
					next_r.phase = 2'h0;
					next_r.state = BITS;
				end else begin
					next_r.quiet_cnt = r.quiet_cnt - 8'h01;
				end
			end
			BITS: begin
				if (tick) begin
					next_r.phase = r.phase + 2'h1;
					unique case (r.phase)
						2'h0: begin
							if (r.bitn != BYTE_BITS) begin
								next_r.sda_oe = sending && !r.shreg[7];
							end else begin
								// Acknowledge byte 0, not the last byte
								next_r.sda_oe = !sending && r.byte_idx == 2'h1;
							end
						end
						2'h1: next_r.scl_oe = 1'b0;
						2'h2: begin
							if (r.bitn != BYTE_BITS) begin
								next_r.rx = {r.rx[6:0], r.sda_sync};
							end else begin
								next_r.acked = !r.sda_sync;
							end
						end
						2'h3: begin
							next_r.scl_oe = 1'b1;
							if (r.bitn != BYTE_BITS) begin
								next_r.shreg = {r.shreg[6:0], 1'b0};
								next_r.bitn  = r.bitn + 4'h1;
							end else begin
								next_r.bitn     = 4'h0;
								next_r.byte_idx = r.byte_idx + 2'h1;
								if (sending && !r.acked) begin
									next_r.refused = 1'b1;
									next_r.sda_oe  = 1'b1;
									next_r.state   = STOP;
								end else if (r.byte_idx == 2'h0) begin
									next_r.shreg = r.command;
								end else if (r.byte_idx == 2'h1 && r.read) begin
									next_r.byte0 = r.rx;
								end else begin
									if (r.read) begin
										next_r.result = 10'({r.byte0, r.rx} >> RESULT_BYTE1_SHIFT);
									end else begin
										next_r.conv_started = 1'b1;
										next_r.ref_seen     = r.command[CMD_REFERENCE_POWER];
										// Reference re-enabled after off needs settling
										next_r.settle_due = r.command[CMD_REFERENCE_POWER]
											&& !r.ref_seen;
									end
									if (r.hold) begin
										// Bus kept with SCL low; next request restarts
										next_r.done  = 1'b1;
										next_r.state = HELD;
									end else begin
										next_r.sda_oe = 1'b1;
										next_r.state  = STOP;
									end
								end
							end
						end
					endcase
				end
			end
			STOP: begin
				if (tick) begin
					next_r.phase = r.phase + 2'h1;
					unique case (r.phase)
						2'h0: next_r.sda_oe = 1'b1;
						2'h1: next_r.scl_oe = 1'b0;
						2'h2: next_r.sda_oe = 1'b0;
						2'h3: begin
							next_r.done  = 1'b1;
							next_r.state = IDLE;
						end
					endcase
				end
			end
			default: next_r.state = IDLE;
		endcase

		// The reference turns on at the stop or restart; settling is counted from the end of the last byte
		if (next_r.settle_due && (next_r.state == STOP || next_r.state == HELD)
			&& r.state == BITS) begin
			next_r.settle_cnt = 17'(SETTLE_CYCLES);
			next_r.settle_due = 1'b0;
			next_r.busy       = 1'b1;
		end
	end

	// Power-up time passes within the first bits at this rate
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign bus.host_scl_o  = 1'b0;
	assign bus.host_scl_oe = r.scl_oe;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = r.sda_oe;
	assign o_busy          = r.busy;
	assign o_done          = r.done;
	assign o_refused       = r.refused;
	assign o_result        = r.result;
endmodule

// ---- verif/adc_i2c_monitor.sv ----
// Concurrent checks on the two-wire link between the converter and its master.
// Assumes it sits beside the link instance and also sees the address straps.
`timescale 1ns/1ps
module adc_i2c_monitor (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Address straps
	input wire logic i_device_select_pin_hi,
	input wire logic i_device_select_pin_lo,
	// Link
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	import adc_i2c_pkg::*;
	logic       prev_scl, prev_sda, busy, after_sr, addr_phase, wrote;
	logic [3:0] bits;
	logic [7:0] shreg, quiet;
	logic [6:0] own_addr;
	logic       start_c, stop_c, scl_rise, ack_slot;
	assign own_addr = {DEVICE_TYPE_PREFIX, i_device_select_pin_hi, i_device_select_pin_lo};
	assign start_c = prev_scl && scl && prev_sda && !sda;
	assign stop_c = prev_scl && scl && !prev_sda && sda;
	assign scl_rise = !prev_scl && scl;
	assign ack_slot = scl_rise && addr_phase && bits == 4'h8;
	// Bit count restarts at every start, so a lost edge cannot skew later frames
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			{prev_scl, prev_sda, busy, after_sr, addr_phase, wrote, bits, shreg, quiet} <= '0;
		end else begin
			prev_scl <= scl;
			prev_sda <= sda;
			quiet <= start_c ? 8'h0 : quiet + {7'h0, quiet != 8'hff};
			if (scl_rise) begin
				shreg <= {shreg[6:0], sda};
				bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
			end
			if (ack_slot && !sda && !shreg[0])
				wrote <= 1'b1;
			if (start_c) begin
				busy <= 1'b1;
				bits <= 4'h0;
			end else if (stop_c)
				busy <= 1'b0;
			after_sr <= start_c ? busy : after_sr && !scl_rise;
			addr_phase <= start_c || (addr_phase && !ack_slot);
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	property p_nack_foreign; ack_slot && shreg[7:1] != own_addr |-> sda; endproperty
	a_nack_foreign: assert property (p_nack_foreign) else $error("foreign address acked");
	property p_nack_early_read; ack_slot && shreg[0] && !wrote |-> sda; endproperty
	a_nack_early_read: assert property (p_nack_early_read) else $error("early read acked");
	property p_sda_steady; scl [*3] |-> $stable(dev_sda_oe); endproperty
	a_sda_steady: assert property (p_sda_steady) else $error("device moved sda in high");
	property p_quiet; scl_rise && after_sr |-> quiet >= QUIET_CYCLES; endproperty
	a_quiet: assert property (p_quiet) else $error("clocked too soon after restart");
	property p_free_after_stop; stop_c |=> !dev_sda_oe [*8]; endproperty
	a_free_after_stop: assert property (p_free_after_stop) else $error("sda held after stop");
	property p_idle_quiet; !busy |-> !dev_sda_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("device drove idle bus");
	property p_ack_own; ack_slot && shreg[7:1] == own_addr && !shreg[0] |-> !sda; endproperty
	a_ack_own: assert property (p_ack_own) else $error("own write address not acked");
	property p_scl_width; $rose(scl) |-> scl [*5]; endproperty
	a_scl_width: assert property (p_scl_width) else $error("clock high phase too short");
	c_ack: cover property (ack_slot && !sda);
	c_restart: cover property (start_c && busy);
	c_read_nack: cover property (scl_rise && !addr_phase && bits == 4'h8 && sda);
endmodule

// ---- verif/tb_i2c_adc_conversion_sequencer.sv ----
// Bench joining the converter sequencer and its master over the link.
// Assumes 40 MHz; a small converter core model answers each conversion.
`timescale 1ns/1ps
module tb_i2c_adc_conversion_sequencer;
	import adc_i2c_pkg::*;
	localparam int BOUND = 4000;
	logic        i_clock, i_resetn = 1'b0, pin_hi = 1'b1, pin_lo = 1'b0;
	logic [9:0]  core_result = '0, result, last_result = '0;
	logic        core_valid = 1'b0, convert_start, converter_on, converter_ready;
	logic        reference_on, single_ended, busy, done, refused, got_refused;
	logic [2:0]  channel;
	logic        req = 1'b0, req_read = 1'b0, req_hold = 1'b0, use_intref = 1'b0;
	logic        watch_ref = 1'b0, ref_dropped = 1'b0, dev_resetn = 1'b1;
	logic [7:0]  command = '0;
	logic [1:0]  dev_sel = 2'h2;
	logic [27:0] wire_bits = '0;
	int          num_errors = 0, comparisons = 0, seed = 32'h29ba, conv_cnt = 0, conv_count = 0;
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	adc_i2c_link link ();
	adc_sequencer_device adc_sequencer_device_i (
		.i_clock(i_clock), .i_resetn(i_resetn && dev_resetn), .bus(link.device),
		.i_device_select_pin_hi(pin_hi), .i_device_select_pin_lo(pin_lo),
		.i_result(core_result), .i_result_valid(core_valid), .o_convert_start(convert_start),
		.o_converter_on(converter_on), .o_converter_ready(converter_ready),
		.o_reference_on(reference_on), .o_channel(channel), .o_single_ended(single_ended)
	);
	adc_sequencer_host #(.SETTLE_CYCLES(50)) adc_sequencer_host_i (
		.i_clock(i_clock), .i_resetn(i_resetn), .bus(link.host), .i_request(req),
		.i_request_read(req_read), .i_request_hold(req_hold), .i_command(command),
		.i_use_internal_reference(use_intref), .i_device_select(dev_sel),
		.o_busy(busy), .o_done(done), .o_refused(refused), .o_result(result)
	);
	adc_i2c_monitor adc_i2c_monitor_i (
		.i_clock(i_clock), .i_resetn(i_resetn && dev_resetn), .i_device_select_pin_hi(pin_hi),
		.i_device_select_pin_lo(pin_lo), .host_scl_o(link.host_scl_o),
		.host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
		.host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda)
	);
	// Converter core stand-in: a fresh random result 8 cycles after each start
	always @(negedge i_clock) begin
		core_valid <= 1'b0;
		if (watch_ref && reference_on !== 1'b1)
			ref_dropped <= 1'b1;
		if (conv_cnt == 1) begin
			last_result = 10'($random(seed));
			core_result <= last_result;
			core_valid <= 1'b1;
		end
		if (conv_cnt != 0)
			conv_cnt <= conv_cnt - 1;
		else if (convert_start === 1'b1) begin
			conv_cnt <= 8;
			conv_count <= conv_count + 1;
		end
	end
	always @(posedge link.scl)
		wire_bits <= {wire_bits[26:0], link.sda};
	task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic step(inout int n);
		n++;
		if (n > BOUND) begin
			num_errors++;
			give_verdict();
		end else
			@(negedge i_clock);
	endtask
	task automatic transfer(input logic rd, hold, input logic [7:0] cmd, input logic intref,
		input logic [1:0] sel);
		int n;
		n = 0;
		while (busy !== 1'b0)
			step(n);
		{req, req_read, req_hold, command, use_intref, dev_sel} = {1'b1, rd, hold, cmd, intref, sel};
		@(negedge i_clock);
		req = 1'b0;
		got_refused = 1'b0;
		while (done !== 1'b1) begin
			got_refused |= refused === 1'b1;
			step(n);
		end
		got_refused |= refused === 1'b1;
		// Lets the device see the stop, when one was sent, before anything is judged
		repeat (8) @(negedge i_clock);
	endtask
	initial begin
		logic [7:0] cmd;
		int         starts;
		repeat (12) @(negedge i_clock);
		i_resetn = 1'b1;
		repeat (8) @(negedge i_clock);
		check("reference_on", 1'b0, reference_on);
		check("converter_on", 1'b0, converter_on);
		transfer(1'b1, 1'b0, 8'h00, 1'b0, 2'h2);
		check("early read refused", 1'b1, got_refused);
		transfer(1'b0, 1'b0, 8'hf4, 1'b0, 2'h1);
		check("foreign address refused", 1'b1, got_refused);
		check("conversions", 28'h0, 28'(conv_count));
		$display("test refusals done");
		for (int m = 0; m < 4; m++) begin
			cmd = 8'($random(seed));
			cmd[3:2] = 2'(m);
			starts = conv_count;
			watch_ref = (m == 3);
			transfer(1'b0, 1'b0, cmd, cmd[3], 2'h2);
			watch_ref = 1'b0;
			check("convert_start", 28'(starts + 1), 28'(conv_count));
			check("channel", {cmd[7], cmd[6:4]}, {single_ended, channel});
			check("reference_on", cmd[3], reference_on);
			check("converter_on", cmd[2], converter_on);
			repeat (60) @(negedge i_clock);
			check("converter_ready", cmd[2], converter_ready);
			transfer(1'b1, 1'b0, 8'h00, 1'b0, 2'h2);
			check("result", last_result, result);
			check("read frame", {DEVICE_TYPE_PREFIX, 3'h5, 1'b0, last_result[9:2], 1'b0,
				last_result[1:0], 7'h01}, wire_bits[27:1]);
			$display("test power mode %0d done", m);
		end
		check("reference kept", 1'b0, ref_dropped);
		transfer(1'b0, 1'b1, 8'h84, 1'b0, 2'h2);
		check("reference off", 1'b0, reference_on);
		transfer(1'b0, 1'b1, 8'h94, 1'b1, 2'h2);
		check("reference before restart", 1'b0, reference_on);
		check("settle busy", 1'b1, busy);
		transfer(1'b1, 1'b0, 8'h00, 1'b0, 2'h2);
		check("reference at restart", 1'b1, reference_on);
		check("result after restart", last_result, result);
		$display("test repeated start done");
		// Device and monitor alone are reset, so the master still believes a conversion ran
		dev_resetn = 1'b0;
		repeat (3) @(negedge i_clock);
		dev_resetn = 1'b1;
		repeat (8) @(negedge i_clock);
		check("reference after reset", 1'b0, reference_on);
		transfer(1'b1, 1'b0, 8'h00, 1'b0, 2'h2);
		check("device refuses early read", 1'b1, got_refused);
		$display("test device reset done");
		give_verdict();
	end
endmodule
